// *** rtl/adc_result_ctrl.sv ***
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
// Notes on behaviour
// - single-ended tracking never shorter than 500 ns, whatever the setting
// - two-bit tracking field adds converter clock cycles to tracking
// - differential tracking lasts half an amplifier clock period
// - result bytes updated no later than the done flag rises
// - single-ended result is unsigned 10-bit code, 0 to 0x3FF
// - differential result is 10-bit two's complement, 0x200 to 0x1FF
// - bit 9 in the high byte is the sign for differential results
// - alignment bit selects left or right layout in the byte pair
// - channel msb written first; low field write commits both
// - alignment change re-presents the stored result at once
// - reference field: ext pin, supply, 1.5 V, 1.6 V
module adc_result_ctrl #(
   parameter int PRESCALE_W = 3,
   parameter int TRACK_W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog core
   input wire logic comparator_in,
   input wire logic amplifier_clock,
   input wire logic differential_chan,
   output logic sample_switch,
   output logic [`CONV_BITS-1:0] dac_code,
   output logic [5:0] active_channel,
   output adc_ctrl_pkg::ref_onehot_t reference_onehot,
   output logic converting,
   // interrupt
   output logic irq
);
   typedef enum logic [1:0] {IDLE, TRACK, CONVERT} state_t;
   state_t state_q;

   logic [7:0] chanref_q, ctrl_a_q, ctrl_b_q, ctrl_c_q;
   logic [5:0] chan_act_q;
   logic done_q;
   logic [`IRQ_W-1:0] stat_q, mask_q;
   logic [PRESCALE_W-1:0] div_q;
   logic [`CONV_BITS-1:0] sar_q, trial_q;
   logic [3:0] bit_q;
   logic diff_q;
   logic [`RESULT_W-1:0] result_q;
   logic result_diff_q;
   logic cmp_s1_q, cmp_s2_q, ack_s1_q, ack_s2_q, ack_s3_q;
   logic amp_half_seen_q;

   // bus decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_chanref = paddr == `ADDR_CHANREF;
   wire hit_a = paddr == `ADDR_CTRL_A;
   wire hit_b = paddr == `ADDR_CTRL_B;
   wire hit_c = paddr == `ADDR_CTRL_C;
   wire hit_lo = paddr == `ADDR_RES_LOW;
   wire hit_hi = paddr == `ADDR_RES_HIGH;
   wire hit_st = paddr == `ADDR_IRQ_STAT;
   wire hit_mk = paddr == `ADDR_IRQ_MASK;
   wire mapped = hit_chanref | hit_a | hit_b | hit_c | hit_lo | hit_hi |
      hit_st | hit_mk;
   wire unused_setup = setup;

   wire enabled = ctrl_a_q[`ENABLE_BIT];
   wire start_req = wr && hit_a && pwdata[`START_BIT] && pwdata[`ENABLE_BIT];

   // prescaled converter clock tick
   wire [PRESCALE_W-1:0] div_lim = ctrl_a_q[`PRESCALE_HI:0];
   wire adc_tick = div_q >= div_lim;

   // tracking length in system clocks
   wire [1:0] track_sel = ctrl_c_q[`TRACK_HI:0];
   wire [TRACK_W-1:0] prescale_cyc = TRACK_W'(div_lim) + TRACK_W'(1);
   wire [TRACK_W-1:0] sel_cyc = TRACK_W'(track_sel) * prescale_cyc;
   wire [TRACK_W-1:0] track_len = TRACK_W'(`MIN_TRACK_CYC) + sel_cyc;

   // amplifier clock synchroniser; second stage feeds the edge detect
   wire amp_fall = ack_s3_q && !ack_s2_q;
   wire amp_rise = !ack_s3_q && ack_s2_q;

   wire trk_busy, trk_done;
   track_timer #(.CW(TRACK_W)) u_track (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(state_q == IDLE && start_req && !differential_chan),
      .length(track_len),
      .busy(trk_busy),
      .done(trk_done)
   );

   // differential: track from amplifier clock rise to its fall
   wire diff_track_end = diff_q && amp_half_seen_q && amp_fall;
   wire track_end = (state_q == TRACK) && (diff_q ? diff_track_end :
      trk_done);
   wire conv_last = (state_q == CONVERT) && adc_tick && (bit_q == 4'h0);
   wire [`CONV_BITS-1:0] sar_next = cmp_s2_q ? sar_q : (sar_q & ~trial_q);
   // differential output of core is offset binary; flip msb to 2s comp
   wire [`RESULT_W-1:0] final_code = diff_q ?
      {~sar_next[`SIGN_POS], sar_next[`SIGN_POS-1:0]} : sar_next;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         cmp_s1_q <= comparator_in;
         cmp_s2_q <= cmp_s1_q;
         ack_s1_q <= amplifier_clock;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   // restart at conversion start so the first trial bit gets a full tick
   // through the comparator synchroniser; prescale below 3 outruns it
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_q == IDLE || adc_tick || track_end)
         div_q <= '0;
      else
         div_q <= div_q + PRESCALE_W'(1);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= IDLE;
         sar_q <= '0;
         trial_q <= '0;
         bit_q <= 4'h0;
         diff_q <= 1'b0;
         amp_half_seen_q <= 1'b0;
      end else begin
         unique case (state_q)
            IDLE: if (start_req) begin
               state_q <= TRACK;
               diff_q <= differential_chan;
               amp_half_seen_q <= 1'b0;
            end
            TRACK: begin
               if (amp_rise)
                  amp_half_seen_q <= 1'b1;
               if (track_end) begin
                  state_q <= CONVERT;
                  trial_q <= 10'h200;
                  sar_q <= 10'h200;
                  bit_q <= 4'(`CONV_BITS - 1);
               end
            end
            CONVERT: if (adc_tick) begin
               trial_q <= trial_q >> 1;
               sar_q <= sar_next | (trial_q >> 1);
               bit_q <= bit_q - 4'h1;
               if (bit_q == 4'h0)
                  state_q <= IDLE;
            end
            default: state_q <= IDLE;
         endcase
      end
   end

   // result stored at the same edge the done flag rises
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         result_q <= '0;
         result_diff_q <= 1'b0;
      end else if (conv_last) begin
         result_q <= final_code;
         result_diff_q <= diff_q;
      end
   end

   // registers; channel msb held in a buffer until low field write
   wire chanref_wr = wr && hit_chanref;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         chanref_q <= 8'h00;
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= 8'h00;
         ctrl_c_q <= 8'h00;
         chan_act_q <= 6'h00;
         mask_q <= '0;
      end else begin
         if (chanref_wr) begin
            chanref_q <= pwdata[7:0];
            chan_act_q <= {ctrl_b_q[`CHAN_MSB_BIT],
               pwdata[`CHAN_LO_HI:0]};
         end
         if (wr && hit_a)
            ctrl_a_q <= {pwdata[7], 1'b0, pwdata[5:0]};
         if (wr && hit_b)
            ctrl_b_q <= pwdata[7:0];
         if (wr && hit_c)
            ctrl_c_q <= pwdata[7:0];
         if (wr && hit_mk)
            mask_q <= pwdata[`IRQ_W-1:0];
      end
   end

   // done flag: set wins over a software clear
   wire done_clr = wr && hit_a && pwdata[`DONE_BIT];
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         done_q <= 1'b0;
      else if (conv_last)
         done_q <= 1'b1;
      else if (done_clr)
         done_q <= 1'b0;
   end

   // sticky status, cleared by a read, new events win
   wire [`IRQ_W-1:0] events = {start_req && state_q != IDLE, conv_last};
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         stat_q <= '0;
      else if (rd && hit_st)
         stat_q <= events;
      else
         stat_q <= stat_q | events;
   end

   // presented result follows the alignment bit live
   adc_ctrl_pkg::result_t res_view;
   assign res_view.left_align = chanref_q[`ALIGN_BIT];
   assign res_view.differential = result_diff_q;
   assign res_view.code = result_q;
   wire [7:0] res_lo, res_hi;
   result_formatter u_fmt (
      .res(res_view),
      .low_byte(res_lo),
      .high_byte(res_hi)
   );

   wire [7:0] ctrl_a_view = {ctrl_a_q[7], state_q != IDLE, ctrl_a_q[5],
      done_q, ctrl_a_q[3:0]};
   wire [7:0] rd_byte =
      hit_chanref ? chanref_q :
      hit_a ? ctrl_a_view :
      hit_b ? ctrl_b_q :
      hit_c ? ctrl_c_q :
      hit_lo ? res_lo :
      hit_hi ? res_hi :
      hit_st ? 8'(stat_q) :
      hit_mk ? 8'(mask_q) : 8'h00;

   assign prdata = {24'h000000, rd_byte};
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // reference decode
   wire [1:0] ref_field = chanref_q[`REF_SEL_HI:`REF_SEL_LO];
   assign reference_onehot.ext_pin = ref_field == 2'h0;
   assign reference_onehot.analog_supply = ref_field == 2'h1;
   assign reference_onehot.int_1v5 = ref_field == 2'h2;
   assign reference_onehot.int_1v6 = ref_field == 2'h3;

   // differential: switch closed only in the amplifier clock's high half
   assign sample_switch = (state_q == TRACK) &&
      (!diff_q || amp_half_seen_q);
   assign dac_code = sar_q;
   assign active_channel = chan_act_q;
   assign converting = state_q != IDLE;
   assign irq = |(stat_q & mask_q);

   // cycles the switch has been closed, for the minimum tracking check
   logic [TRACK_W-1:0] track_seen_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !sample_switch)
         track_seen_q <= '0;
      else
         track_seen_q <= track_seen_q + TRACK_W'(1);
   end

   a_min_track: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (track_end && !diff_q) |->
      track_seen_q >= TRACK_W'(`MIN_TRACK_CYC - 1))
      else $error("tracking shorter than minimum");
   a_done_result: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      $rose(done_q) |-> result_q == $past(final_code))
      else $error("result not ready with done flag");
   a_align_live: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      chanref_q[`ALIGN_BIT] |-> res_lo[5:0] == 6'h00)
      else $error("left layout low bits not zero");
   a_right_zero: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      !chanref_q[`ALIGN_BIT] |-> res_hi[7:2] == 6'h00)
      else $error("right layout upper bits not zero");
   a_chan_commit: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      chanref_wr |=> chan_act_q[5] == $past(ctrl_b_q[`CHAN_MSB_BIT]))
      else $error("channel msb not committed");
   a_diff_track: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state_q == TRACK && diff_q && amp_fall && amp_half_seen_q)
      |=> state_q == CONVERT)
      else $error("differential tracking not ended");
   a_ref_onehot: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      $onehot(reference_onehot))
      else $error("reference decode not one-hot");
   a_sign_bit: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (result_diff_q && !chanref_q[`ALIGN_BIT]) |->
      res_hi[1] == result_q[`SIGN_POS])
      else $error("sign bit misplaced");
   c_conv_done: cover property (@(posedge sys_clk) $rose(done_q));
   c_diff_conv: cover property (@(posedge sys_clk) conv_last && diff_q);
   c_irq: cover property (@(posedge sys_clk) $rose(irq));
   c_overlap: cover property (@(posedge sys_clk) events[1]);
endmodule

// *** rtl/adc_ctrl_consts.svh ***
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// register byte addresses on the bus
`define ADDR_CHANREF 12'h000
`define ADDR_CTRL_A 12'h004
`define ADDR_CTRL_B 12'h008
`define ADDR_CTRL_C 12'h00C
`define ADDR_RES_LOW 12'h010
`define ADDR_RES_HIGH 12'h014
`define ADDR_IRQ_STAT 12'h018
`define ADDR_IRQ_MASK 12'h01C
// channel_reference_reg fields
`define REF_SEL_HI 7
`define REF_SEL_LO 6
`define ALIGN_BIT 5
`define CHAN_LO_HI 4
// converter_control_a fields
`define ENABLE_BIT 7
`define START_BIT 6
`define DONE_BIT 4
`define PRESCALE_HI 2
// converter_control_b field
`define CHAN_MSB_BIT 3
// converter_control_c field
`define TRACK_HI 1
// interrupt status bits
`define IRQ_DONE 0
`define IRQ_OVERLAP 1
`define IRQ_W 2
// timing
`define CLK_MHZ 40
`define MIN_TRACK_NS 500
`define MIN_TRACK_CYC (((`MIN_TRACK_NS * `CLK_MHZ) + 999) / 1000)
`define CONV_BITS 10
`define RESULT_W 10
`define SIGN_POS 9
`endif

// *** rtl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      REF_EXT_PIN,
      REF_ANALOG_SUPPLY,
      REF_INT_1V5,
      REF_INT_1V6
   } reference_t;

   typedef struct packed {
      logic left_align;
      logic differential;
      logic [9:0] code;
   } result_t;

   typedef struct packed {
      logic ext_pin;
      logic analog_supply;
      logic int_1v5;
      logic int_1v6;
   } ref_onehot_t;
endpackage

// *** rtl/result_formatter.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module result_formatter (
   // stored result and layout
   input wire adc_ctrl_pkg::result_t res,
   // presented byte pair
   output logic [7:0] low_byte,
   output logic [7:0] high_byte
);
   wire [15:0] left_pair;
   wire [15:0] right_pair;
   wire [15:0] pair;

   // raw pattern, no sign extension in either layout
   assign left_pair = {res.code, 6'h00};
   assign right_pair = {6'h00, res.code};
   assign pair = res.left_align ? left_pair : right_pair;
   assign low_byte = pair[7:0];
   assign high_byte = pair[15:8];
endmodule

// *** rtl/track_timer.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module track_timer #(
   parameter int CW = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [CW-1:0] length,
   // status
   output logic busy,
   output logic done
);
   logic [CW-1:0] cnt_q;
   logic busy_q;
   wire last;

   assign last = busy_q && (cnt_q <= CW'(1));
   assign busy = busy_q;
   assign done = last;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         cnt_q <= length;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         cnt_q <= cnt_q - CW'(1);
         busy_q <= !last;
      end
   end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module tb;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic comparator_in = 1'h0;
   logic amplifier_clock = 1'h0;
   logic differential_chan = 1'h0;
   logic sample_switch;
   logic [9:0] dac_code;
   logic [5:0] active_channel;
   adc_ctrl_pkg::ref_onehot_t reference_onehot;
   logic converting;
   logic irq;
   logic [9:0] target = 10'h0;
   logic msk = 1'h0;
   logic [31:0] exp_q[$];
   logic err_q[$];
   int error_cnt = 0;
   int n_checks = 0;
   int trk = 0;
   int trk_len = 0;

   adc_result_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_in(comparator_in), .amplifier_clock(amplifier_clock),
      .differential_chan(differential_chan), .sample_switch(sample_switch),
      .dac_code(dac_code), .active_channel(active_channel),
      .reference_onehot(reference_onehot), .converting(converting),
      .irq(irq));

   always #12.5 sys_clk = ~sys_clk;

   // ideal comparator: keeps a trial bit while the trial stays at or below
   always @(posedge sys_clk) comparator_in <= (dac_code <= target);

   // half period of 600 ns, above the minimum tracking time
   always begin
      repeat (24) @(posedge sys_clk);
      amplifier_clock <= ~amplifier_clock;
   end

   // length of the last tracking phase in clocks
   always @(posedge sys_clk) begin
      if (sample_switch === 1'h1) trk <= trk + 1;
      else if (trk != 0) begin
         trk_len <= trk;
         trk <= 0;
      end
   end

   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      n_checks++;
      if (a !== e) begin
         error_cnt++;
         $display("ERROR %0t: got %0h expected %0h", $time, a, e);
      end
   endtask

   // read data and error flag compared against the oldest note
   always @(posedge sys_clk) begin
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
         chk({31'h0, pslverr}, {31'h0, err_q.pop_front()});
         if (pwrite === 1'h0) chk(prdata, exp_q.pop_front());
      end
   end

   // on a read, d is the expected data
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic se);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      if (!w) exp_q.push_back(d);
      err_q.push_back(se);
      do @(posedge sys_clk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic convert(input logic [9:0] t, input logic dif,
                          input logic [1:0] sel, input logic ovl);
      logic [9:0] c;
      int i;
      c = dif ? (t ^ 10'h200) : t;
      target <= t;
      differential_chan <= dif;
      apb(1'h1, `ADDR_CTRL_C, {30'h0, sel}, 1'h0);
      apb(1'h1, `ADDR_CHANREF, 32'h0, 1'h0);
      // slowest conversion clock that the prescaler offers
      apb(1'h1, `ADDR_CTRL_A, 32'hC7, 1'h0);
      if (ovl) apb(1'h1, `ADDR_CTRL_A, 32'hC7, 1'h0);
      // bus left quiet while the conversion runs
      for (i = 0; i < 3000 && converting !== 1'h0; i++)
         @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, converting}, 32'h0);
      if (dif) chk({31'h0, trk_len >= 22 && trk_len <= 26}, 32'h1);
      else chk(trk_len, 20 + sel * 8);
      chk({31'h0, irq}, {31'h0, msk});
      @(posedge sys_clk);
      apb(1'h0, `ADDR_RES_LOW, {24'h0, c[7:0]}, 1'h0);
      apb(1'h0, `ADDR_RES_HIGH, {30'h0, c[9:8]}, 1'h0);
      apb(1'h1, `ADDR_CHANREF, 32'h20, 1'h0);
      apb(1'h0, `ADDR_RES_LOW, {24'h0, c[1:0], 6'h0}, 1'h0);
      apb(1'h0, `ADDR_RES_HIGH, {24'h0, c[9:2]}, 1'h0);
      apb(1'h0, `ADDR_CTRL_A, 32'h97, 1'h0);
      apb(1'h0, `ADDR_IRQ_STAT, {30'h0, ovl, 1'h1}, 1'h0);
      apb(1'h0, `ADDR_IRQ_STAT, 32'h0, 1'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'h1, `ADDR_CTRL_A, 32'h97, 1'h0);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      stop_test();
   end

   initial begin
      logic [31:0] r;
      int k;
      r = $urandom(32'h465801E0);
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(posedge sys_clk);
      for (k = 0; k < 8; k++) apb(1'h0, 12'(k * 4), 32'h0, 1'h0);
      apb(1'h0, 12'h020, 32'h0, 1'h1);
      apb(1'h1, 12'h024, 32'h5A, 1'h1);
      for (k = 0; k < 4; k++) begin
         apb(1'h1, `ADDR_CHANREF, {24'h0, 2'(k), 6'h0}, 1'h0);
         @(negedge sys_clk);
         chk({28'h0, reference_onehot}, {28'h0, 4'h8 >> k});
         @(posedge sys_clk);
      end
      // temperature sensor setup: msb first, then low field and reference
      apb(1'h1, `ADDR_CTRL_B, 32'h08, 1'h0);
      @(negedge sys_clk);
      chk({26'h0, active_channel}, 32'h0);
      @(posedge sys_clk);
      apb(1'h1, `ADDR_CHANREF, 32'hC9, 1'h0);
      @(negedge sys_clk);
      chk({26'h0, active_channel}, 32'h29);
      @(posedge sys_clk);
      apb(1'h0, `ADDR_CTRL_B, 32'h08, 1'h0);
      // masked done must not raise the interrupt
      convert(10'h000, 1'h0, 2'h0, 1'h0);
      msk <= 1'h1;
      apb(1'h1, `ADDR_IRQ_MASK, 32'h1, 1'h0);
      apb(1'h0, `ADDR_IRQ_MASK, 32'h1, 1'h0);
      convert(10'h3FF, 1'h0, 2'h3, 1'h1);
      convert(10'h000, 1'h1, 2'h1, 1'h0);
      convert(10'h3FF, 1'h1, 2'h2, 1'h0);
      for (k = 0; k < 4; k++) begin
         r = $urandom;
         convert(r[9:0], r[10], r[12:11], 1'h0);
      end
      stop_test();
   end
endmodule
